// >>> hdl/clk_ctl_pkg.sv
// package for the clock and sleep control block: register layouts, reset
// values, mode codes and timing counts; assumes a 20 MHz sys_clk.
`default_nettype none
package clk_ctl_pkg;

	// i/o port address shared by both registers
	localparam logic [3:0] CLK_PORT_ADDR = 4'h3;

	// clock management register layout (auxiliary register)
	typedef struct packed {
		logic       peripheral_clock_keep; // bit 3
		logic       ccs;                   // bit 2, core source select
		logic       speed_div_bit_hi;      // bit 1
		logic       speed_div_bit_lo;      // bit 0
	} mgmt_t;

	// system configuration register layout (primary register)
	typedef struct packed {
		logic       brownout_level_sel;   // bit 3, 1 = low level
		logic       unused_bit;           // bit 2
		logic       oscillator_select_hi; // bit 1
		logic       oscillator_select_lo; // bit 0
	} cfg_t;

	localparam logic [3:0] MGMT_RESET = 4'hf;
	localparam logic [3:0] CFG_RESET  = 4'hb;

	// oscillator select codes
	localparam logic [1:0] OS_EXT = 2'h3;
	localparam logic [1:0] OS_RC2 = 2'h1;
	localparam logic [1:0] OS_X4  = 2'h2;
	localparam logic [1:0] OS_X32 = 2'h0;

	// speed select codes
	localparam logic [1:0] DIV16 = 2'h0;
	localparam logic [1:0] DIV8  = 2'h3;
	localparam logic [1:0] DIV4  = 2'h2;
	localparam logic [1:0] DIV2  = 2'h1;

	// one bit per clock source, used for samples and enables
	typedef struct packed {
		logic       rc1;
		logic       rc2;
		logic       x4;
		logic       x32;
		logic       ext;
	} osc_t;

	// power state, one-hot
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b01,
		PWR_SLEEP  = 2'b10
	} pwr_t;

	// timing
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          MISS_TIME_NS  = 1000000;
	localparam int          MISS_CYCLES   = (MISS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          MISS_W        = 16;
	localparam int          XTAL_STAGES   = 14;
	localparam logic [2:0]  SUB_HALF_LAST = 3'h7;

endpackage : clk_ctl_pkg
`default_nettype wire

// >>> hdl/mcu_clock_and_sleep_control.sv
// clock source selection, core divider, external clock supervisor and
// sleep gating; oscillator pins arrive as levels synchronous to sys_clk,
// which runs free and independent of every supervised source.
`default_nettype none

module mcu_clock_and_sleep_control
	import clk_ctl_pkg::*;
#(
	parameter int MISS_LIMIT = MISS_CYCLES
) (
	// clock and reset
	input  wire logic           sys_clk,
	input  wire logic           rst,
	// i/o bus write port
	input  wire logic           io_wr,
	input  wire logic           io_aux,
	input  wire logic [3:0]     io_addr,
	input  wire logic [3:0]     io_data,
	// oscillator outputs and watchdog term
	input  wire osc_t           osc_in,
	input  wire logic           watchdog_sleep_term,
	// core handshake
	input  wire logic           sleep_exec,
	input  wire logic           irq_any,
	// oscillator and brownout controls
	output osc_t                osc_en,
	output logic                brownout_en,
	output logic                brownout_level_sel,
	// generated clocks
	output logic                core_clock,
	output logic                periph_clock,
	output logic                peripheral_subclock,
	// status and events
	output logic                supervisor_reset,
	output logic                ie_set,
	output logic                core_halted,
	output logic                sync_busy
);

	// whole block state
	typedef struct packed {
		mgmt_t              mgmt;
		cfg_t               cfg;
		mgmt_t              app_mgmt;
		logic [1:0]         app_os;
		logic               sync_pend;
		pwr_t               pwr;
		osc_t               prev;
		logic [2:0]         div_cnt;
		logic               sys_lvl;
		logic [2:0]         sub_cnt;
		logic               sub_lvl;
		logic [XTAL_STAGES-1:0] xt_cnt;
		logic               xt_ready;
		logic [MISS_W-1:0]  miss_cnt;
		logic               core_lvl;
		logic               per_lvl;
		logic               sub_out;
		logic               ie_pulse;
	} st_t;

	st_t st_q;
	st_t st_d;

	// last source edge count of a half period for a speed code
	function automatic logic [2:0] half_last(input logic [1:0] code);
		logic [2:0] r;
		r = 3'h0;
		unique case (code)
			DIV16: r = 3'h7;
			DIV8:  r = 3'h3;
			DIV4:  r = 3'h1;
			DIV2:  r = 3'h0;
		endcase
		return r;
	endfunction : half_last

	// edge of the source picked by ccs and the select pair
	function automatic logic pick_edge(input logic ccs, input logic [1:0] os, input osc_t e);
		logic r;
		r = e.rc1;
		if (!ccs) begin
			unique case (os)
				OS_EXT: r = e.ext;
				OS_RC2: r = e.rc2;
				OS_X4:  r = e.x4;
				OS_X32: r = e.x32;
			endcase
		end
		return r;
	endfunction : pick_edge

	logic             osc_stop;
	logic             sup_on;
	logic [1:0]       os_now;
	osc_t             edges;
	logic             cin_edge;
	logic             xt_edge;
	logic             xt_sel;
	logic             mgmt_wr;
	logic             cfg_wr;
	logic             stay_asleep;

	// decode and oscillator control
	always_comb begin
		os_now      = {st_q.cfg.oscillator_select_hi, st_q.cfg.oscillator_select_lo};
		mgmt_wr     = io_wr && io_aux && (io_addr == CLK_PORT_ADDR);
		cfg_wr      = io_wr && !io_aux && (io_addr == CLK_PORT_ADDR);
		osc_stop    = (st_q.pwr == PWR_SLEEP) && !st_q.mgmt.peripheral_clock_keep
		              && watchdog_sleep_term;
		osc_en.rc1  = st_q.app_mgmt.ccs && !osc_stop;
		osc_en.rc2  = (os_now == OS_RC2) && !osc_stop;
		osc_en.x4   = (os_now == OS_X4) && !osc_stop;
		osc_en.ext  = (os_now == OS_EXT) && !osc_stop;
		osc_en.x32  = (os_now == OS_X32);
		brownout_en = !osc_stop;
		sup_on      = (os_now == OS_EXT) && !st_q.app_mgmt.ccs;
		edges       = osc_in & ~st_q.prev;
		xt_sel      = (os_now == OS_X4) || (os_now == OS_X32);
		xt_edge     = (os_now == OS_X4) ? edges.x4 : edges.x32;
		cin_edge    = pick_edge(st_q.app_mgmt.ccs, st_q.app_os, edges);
		// crystal edges count only once the stabilising divider is full
		if (!st_q.app_mgmt.ccs && (st_q.app_os == OS_X4 || st_q.app_os == OS_X32)
		    && !st_q.xt_ready) begin
			cin_edge = 1'b0;
		end
		stay_asleep = !irq_any;
	end

	// next state
	always_comb begin
		st_d          = st_q;
		st_d.prev     = osc_in;
		st_d.ie_pulse = 1'b0;

		// register writes
		if (mgmt_wr) begin
			st_d.mgmt      = mgmt_t'(io_data);
			st_d.sync_pend = 1'b1;
		end
		if (cfg_wr) begin
			st_d.cfg = cfg_t'(io_data);
		end

		// crystal start-up divider, cleared whenever the crystal is off
		if (!xt_sel || !(osc_en.x4 || osc_en.x32)
		    || (cfg_wr && io_data[1:0] != os_now)) begin
			st_d.xt_cnt   = '0;
			st_d.xt_ready = 1'b0;
		end else if (xt_edge && !st_q.xt_ready) begin
			st_d.xt_cnt = st_q.xt_cnt + 1'b1;
			if (&st_q.xt_cnt) begin
				st_d.xt_ready = 1'b1;
			end
		end

		// core divider with synchronised switching
		if (cin_edge) begin
			if (st_q.div_cnt == half_last({st_q.app_mgmt.speed_div_bit_hi,
			                               st_q.app_mgmt.speed_div_bit_lo})) begin
				st_d.div_cnt = 3'h0;
				if (!st_q.sys_lvl && st_q.sync_pend && !mgmt_wr) begin
					// switch only at the end of a full low phase
					st_d.app_mgmt  = st_q.mgmt;
					st_d.app_os    = os_now;
					st_d.sync_pend = 1'b0;
				end else begin
					st_d.sys_lvl = !st_q.sys_lvl;
				end
			end else begin
				st_d.div_cnt = st_q.div_cnt + 1'b1;
			end
		end

		// subclock: input/16, or the 32 kHz crystal directly
		if (cin_edge) begin
			st_d.sub_cnt = st_q.sub_cnt + 1'b1;
			if (st_q.sub_cnt == SUB_HALF_LAST) begin
				st_d.sub_lvl = !st_q.sub_lvl;
			end
		end

		// external clock supervisor, counted on sys_clk
		if (!sup_on || edges.ext) begin
			st_d.miss_cnt = '0;
		end else if (st_q.miss_cnt < MISS_W'(MISS_LIMIT)) begin
			st_d.miss_cnt = st_q.miss_cnt + 1'b1;
		end

		// sleep control
		unique case (st_q.pwr)
			PWR_ACTIVE: begin
				if (sleep_exec) begin
					st_d.ie_pulse = 1'b1;
					if (stay_asleep) begin
						st_d.pwr = PWR_SLEEP;
					end
				end
			end
			PWR_SLEEP: begin
				if (!stay_asleep) begin
					st_d.pwr = PWR_ACTIVE;
				end
			end
		endcase

		// gated clock levels, registered so the outputs cannot glitch
		st_d.core_lvl = st_d.sys_lvl && (st_d.pwr == PWR_ACTIVE);
		st_d.per_lvl  = st_d.sys_lvl && ((st_d.pwr == PWR_ACTIVE)
		                || st_d.mgmt.peripheral_clock_keep);
		if (st_d.app_os == OS_X32 && !st_d.app_mgmt.ccs) begin
			st_d.sub_out = osc_in.x32;
		end else begin
			st_d.sub_out = st_d.sub_lvl;
		end
		if (st_d.pwr == PWR_SLEEP && !st_d.mgmt.peripheral_clock_keep) begin
			st_d.sub_out = 1'b0;
		end
	end

	// state register; reset also ends sleep
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q        <= '0;
			st_q.mgmt     <= mgmt_t'(MGMT_RESET);
			st_q.app_mgmt <= mgmt_t'(MGMT_RESET);
			st_q.cfg      <= cfg_t'(CFG_RESET);
			st_q.app_os   <= CFG_RESET[1:0];
			st_q.pwr    <= PWR_ACTIVE;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs
	assign brownout_level_sel  = st_q.cfg.brownout_level_sel;
	assign core_clock          = st_q.core_lvl;
	assign periph_clock        = st_q.per_lvl;
	assign peripheral_subclock = st_q.sub_out;
	assign supervisor_reset    = sup_on && (st_q.miss_cnt >= MISS_W'(MISS_LIMIT));
	assign ie_set              = st_q.ie_pulse;
	assign core_halted         = (st_q.pwr == PWR_SLEEP);
	assign sync_busy           = st_q.sync_pend;

	// checks
	osc_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
		osc_stop |-> (!osc_en.rc1 && !osc_en.x4 && !osc_en.ext && !brownout_en))
		else $error("oscillator stop left a source running");
	rc1_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
		!st_q.app_mgmt.ccs |-> !osc_en.rc1)
		else $error("first rc running while secondary selected");
	sup_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		supervisor_reset |-> (os_now == OS_EXT && !st_q.app_mgmt.ccs))
		else $error("supervisor reset outside its enabling mode");
	sup_time_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(supervisor_reset) |-> ($past(st_q.miss_cnt) == MISS_W'(MISS_LIMIT - 1)))
		else $error("supervisor fired at the wrong count");
	sleep_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
		(sleep_exec && !core_halted && !irq_any) |=> (ie_set && core_halted))
		else $error("sleep did not set enable and halt");
	wake_up_a: assert property (@(posedge sys_clk) disable iff (rst)
		(core_halted && irq_any) |=> !core_halted)
		else $error("sleep held with interrupt pending");
	core_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		core_halted |-> !core_clock)
		else $error("core clock running in sleep");
	sync_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		mgmt_wr |=> sync_busy)
		else $error("management write did not start synchronisation");
	xtal32_run_a: assert property (@(posedge sys_clk) disable iff (rst)
		(os_now == OS_X32) |-> osc_en.x32)
		else $error("32 kHz crystal stopped while selected");
	no_short_a: assert property (@(posedge sys_clk) disable iff (rst)
		$changed(st_q.app_mgmt) |-> (!st_q.sys_lvl && st_q.div_cnt == 3'h0))
		else $error("settings applied outside a low phase boundary");

endmodule : mcu_clock_and_sleep_control
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the clock and sleep control block
// assumes clk_ctl_pkg and the design files are compiled first
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import clk_ctl_pkg::*;

	logic       sys_clk, rst, io_wr, io_aux, wdt, sleep_exec, irq_any;
	logic [3:0] io_addr, io_data;
	osc_t       osc, osc_en;
	logic       bo_en, bo_lvl, core_clk, per_clk, sub_clk, sup_rst, ie_set, halted, busy;
	logic       p_core, p_per, p_sub;
	int         n_fail, n_tests, m_ccs, m_os;
	int         c_core, c_per, c_sub, d_core, d_per, d_sub;
	logic [1:0] dv [4] = '{DIV16, DIV8, DIV4, DIV2};
	int         dn [4] = '{16, 8, 4, 2};

	mcu_clock_and_sleep_control #(.MISS_LIMIT(20)) u_mcu_clock_and_sleep_control (
		.sys_clk(sys_clk), .rst(rst), .io_wr(io_wr), .io_aux(io_aux),
		.io_addr(io_addr), .io_data(io_data), .osc_in(osc), .watchdog_sleep_term(wdt),
		.sleep_exec(sleep_exec), .irq_any(irq_any), .osc_en(osc_en), .brownout_en(bo_en),
		.brownout_level_sel(bo_lvl), .core_clock(core_clk), .periph_clock(per_clk),
		.peripheral_subclock(sub_clk), .supervisor_reset(sup_rst), .ie_set(ie_set),
		.core_halted(halted), .sync_busy(busy));

	// 20 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// count level changes of the generated clocks
	always @(posedge sys_clk) begin
		c_core <= c_core + (core_clk !== p_core);
		c_per  <= c_per + (per_clk !== p_per);
		c_sub  <= c_sub + (sub_clk !== p_sub);
		p_core <= core_clk;
		p_per  <= per_clk;
		p_sub  <= sub_clk;
	end

	task automatic test_done;
		if (n_fail == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic near(input int d, input int e);
		return d - e <= 1 && e - d <= 1;
	endfunction : near

	// model of the oscillator enables from the written settings
	function automatic osc_t exp_osc(input logic stop);
		exp_osc.rc1 = m_ccs == 1 && !stop;
		exp_osc.rc2 = m_os == 1 && !stop;
		exp_osc.x4  = m_os == 2 && !stop;
		exp_osc.x32 = m_os == 0;
		exp_osc.ext = m_os == 3 && !stop;
	endfunction : exp_osc

	// one-cycle write strobe on the i/o bus
	task automatic wr(input logic aux, input logic [3:0] a, input logic [3:0] d);
		@(negedge sys_clk);
		{io_wr, io_aux, io_addr, io_data} = {1'b1, aux, a, d};
		@(negedge sys_clk);
		io_wr = 1'b0;
		if (a == CLK_PORT_ADDR && !aux) m_os = d[1:0];
	endtask : wr

	// rising edges on one source: 0 rc1, 1 rc2, 2 x4, 3 x32, 4 ext
	task automatic edges(input int s, input int n);
		repeat (n) begin
			@(negedge sys_clk);
			osc[4-s] = 1'b1;
			@(negedge sys_clk);
			osc[4-s] = 1'b0;
		end
	endtask : edges

	// feed the old source until the new settings are applied
	task automatic sync(input int s, input int ccs);
		chk(busy, 1'b1);
		for (int i = 0; i < 40 && busy === 1'b1; i++) edges(s, 1);
		chk(busy, 1'b0);
		m_ccs = ccs;
		chk(osc_en, exp_osc(1'b0));
	endtask : sync

	// toggles of the generated clocks over n source edges
	task automatic meas(input int s, input int n);
		int b_core;
		int b_per;
		int b_sub;
		b_core = c_core;
		b_per = c_per;
		b_sub = c_sub;
		edges(s, n);
		repeat (2) @(negedge sys_clk);
		d_core = c_core - b_core;
		d_per = c_per - b_per;
		d_sub = c_sub - b_sub;
	endtask : meas

	task automatic slp(input logic irq);
		@(negedge sys_clk);
		{sleep_exec, irq_any} = {1'b1, irq};
		@(negedge sys_clk);
		sleep_exec = 1'b0;
		chk({ie_set, halted}, {1'b1, !irq});
		@(negedge sys_clk);
		irq_any = 1'b0;
		chk(ie_set, 1'b0);
	endtask : slp

	task automatic wake;
		@(negedge sys_clk);
		irq_any = 1'b1;
		@(negedge sys_clk);
		chk(halted, 1'b0);
		irq_any = 1'b0;
	endtask : wake

	// watchdog on the whole run
	initial begin
		repeat (90000) @(posedge sys_clk);
		n_fail++;
		test_done();
	end

	initial begin
		{io_wr, io_aux, io_addr, io_data, wdt, sleep_exec, irq_any} = '0;
		{n_fail, n_tests} = '0;
		rst = 1'b1;
		osc = '0;
		m_ccs = 1;
		m_os = 3;
		void'($urandom(32'h5e51b856));
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		// reset state
		chk(osc_en, exp_osc(1'b0));
		chk({bo_en, bo_lvl, busy, halted, sup_rst}, 5'b11000);
		// a write to another port is ignored
		wr(1'b1, 4'h4 + 4'($urandom_range(14)), 4'($urandom));
		chk(busy, 1'b0);
		// every divider code on the first rc
		for (int i = 0; i < 4; i++) begin
			wr(1'b1, CLK_PORT_ADDR, {2'b11, dv[i]});
			sync(0, 1);
			meas(0, 64);
			chk(near(d_core, 64 / (dn[i] / 2)), 1'b1);
			chk(near(d_sub, 8), 1'b1);
			chk(near(d_per, d_core), 1'b1);
		end
		chk(sup_rst, 1'b0);
		// sleep with full oscillator stop, then wake
		wdt = 1'b1;
		wr(1'b1, CLK_PORT_ADDR, 4'h5);
		sync(0, 1);
		slp(1'b0);
		chk({osc_en, bo_en}, {exp_osc(1'b1), 1'b0});
		meas(0, 16);
		chk(16'(d_core + d_per), 16'h0);
		chk(halted, 1'b1);
		wake();
		slp(1'b1);
		// sleep with the peripheral clock kept
		wr(1'b1, CLK_PORT_ADDR, 4'hd);
		sync(0, 1);
		slp(1'b0);
		chk(osc_en, exp_osc(1'b0));
		meas(0, 16);
		chk(16'(d_core), 16'h0);
		chk(near(d_per, 16), 1'b1);
		wake();
		// external clock supervisor
		wdt = 1'b0;
		wr(1'b0, CLK_PORT_ADDR, 4'h7);
		chk(bo_lvl, 1'b0);
		wr(1'b1, CLK_PORT_ADDR, 4'h9);
		sync(0, 0);
		edges(4, 8);
		chk(sup_rst, 1'b0);
		repeat (16) @(negedge sys_clk);
		chk(sup_rst, 1'b0);
		repeat (8) @(negedge sys_clk);
		chk(sup_rst, 1'b1);
		edges(4, 1);
		chk(sup_rst, 1'b0);
		// 32 kHz crystal behind its start-up divider
		wr(1'b0, CLK_PORT_ADDR, 4'h8);
		chk(bo_lvl, 1'b1);
		wr(1'b1, CLK_PORT_ADDR, 4'h1);
		sync(4, 0);
		meas(3, 16000);
		chk(16'(d_core), 16'h0);
		meas(3, 600);
		chk(d_core > 200 && d_core < 230, 1'b1);
		@(negedge sys_clk);
		osc.x32 = 1'b1;
		@(negedge sys_clk);
		chk(sub_clk, 1'b1);
		osc.x32 = 1'b0;
		@(negedge sys_clk);
		chk(sub_clk, 1'b0);
		wdt = 1'b1;
		slp(1'b0);
		chk(osc_en, exp_osc(1'b1));
		wake();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
